// ---- design/pse_event_defines.vh ----
// What this block does
// - Each channel's current-limit flag updates on its own
// - Each dual-signature channel's start fault flag updates on its own
// - Start fault with enable-change flag means inrush fault
// - Start fault without enable-change logs cause code
// - Automatic mode ignores invalid discovery start faults
// - Dual-signature channel restarts on power-on command
// - Low-class single-signature inrush on primary channel only
// - Clean low-class inrush turns secondary on, power good
// - Low-class inrush fault: both off, cool-down, both flags
// - High-class single-signature inrush on both channels together
// - Clean high-class inrush sets power good, stays on
// - High-class inrush fault: both off, cool-down, both flags
// - Dual-signature channels run inrush independently
// - Two codes read supply events, second one clears
// - Clear-on-read releases interrupt caused by this register
// - Set supply event bits feed interrupt summary
// - Bit 7 thermal shutdown, all channels off, preserved
// - Channels may restart once temperature below low threshold; code allows restart as soon as temp_over (high threshold) drops
// - Bit 6 logic lockout, powers up 1, preserved
// - Bit 5 logic warning, powers up 1, preserved
// - Bit 4 main rail undervoltage, powers up 1, preserved
// - Bits 3 and 2 summed overload, cleared by resets
// - Bit 1 fast shutdown or priority code disable
// - Bit 0 program memory fault, cleared by resets
// - Preserved bits survive pin reset, only power-on reloads them
`ifndef PSE_EVENT_DEFINES_VH
`define PSE_EVENT_DEFINES_VH

// ----------------------------------------
// Command codes of the management port
// ----------------------------------------
`define CMD_SI_VIEW   8'h08
`define CMD_SI_CLR    8'h09
`define CMD_SF_VIEW   8'h0a
`define CMD_SF_CLR    8'h0b
`define CMD_PON_FLT   8'h24

// ----------------------------------------
// Supply_fault_events_clear bit positions
// ----------------------------------------
`define SF_THERMAL    7
`define SF_LOCKOUT    6
`define SF_WARNING    5
`define SF_MAIN_UV    4
`define SF_OVL34      3
`define SF_OVL12      2
`define SF_FAST_SHUT  1
`define SF_MEM_FLT    0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SF_POR_VAL    8'h70
`define SF_KEEP_MASK  8'hf0
`define SI_RST_VAL    8'h00
`define PF_RST_VAL    8'h00

// ----------------------------------------
// Power-on fault cause codes (two bits per channel)
// ----------------------------------------
`define CAUSE_DISC    2'h1

// ----------------------------------------
// Channel states, one-hot
// ----------------------------------------
`define ST_IDLE       4'h1
`define ST_INRUSH     4'h2
`define ST_ON         4'h4
`define ST_COOL       4'h8

// ----------------------------------------
// Timing
// ----------------------------------------
`define COOL_MS       1000
`define CLK_KHZ       40000
`define COOL_CYC      (`COOL_MS * `CLK_KHZ)

`endif

// ---- design/port_inrush_seq.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pse_event_defines.vh"

module port_inrush_seq #(
  parameter integer COOL_CYCLES = `COOL_CYC,  // Cool-down length in cycles
  parameter integer CNT_W       = 26          // Cool-down counter width
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,          // Any reset, synchronous
  // Port configuration
  input  wire       dual_sig,     // Load has two signatures
  input  wire       class_hi,     // Assigned class 7 or 8
  input  wire       temp_over,    // Die above high threshold
  // Per channel stimulus
  input  wire [1:0] pwr_req,      // Power-on command pulse
  input  wire [1:0] grant_ok,     // Discovery valid, allocation fits
  input  wire [1:0] inrush_end,   // End of inrush window pulse
  input  wire [1:0] start_flt,    // Start fault at inrush end
  input  wire [1:0] ilim_flt,     // Current-limit timeout pulse
  // Per channel results
  output wire [1:0] ch_on,        // Channel switch enabled
  output wire [1:0] pg,           // Power good
  output wire [1:0] cooling,      // Cool-down in progress
  output reg  [1:0] sflt_evt_r,   // Start fault event pulse
  output reg  [1:0] ilim_evt_r    // Current-limit event pulse
);

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  reg  [3:0]       st_r   [0:1];  // Channel state
  reg  [3:0]       st_nxt [0:1];  // Channel next state
  reg  [CNT_W-1:0] cnt_r  [0:1];  // Cool-down counter
  reg  [1:0]       done_r;        // Inrush ended clean, awaiting partner
  wire [1:0]       in_inr;        // Channel in inrush
  wire [1:0]       in_on;         // Channel powered
  wire [1:0]       ok_end;        // Clean inrush end
  wire [1:0]       bad_end;       // Faulted inrush end
  wire             ss;            // Single-signature port
  wire             ss_fail;       // Port-level inrush failure
  wire             ss_ok;         // Port-level inrush success
  wire             ss_ilim;       // Current-limit on either channel

  assign ss      = ~dual_sig;
  assign ss_fail = ss & (bad_end[0] | bad_end[1]);
  // Low class waits on primary only, high class on both
  assign ss_ok   = ss & ~ss_fail & (class_hi ?
                   ((ok_end[0] | done_r[0]) & (ok_end[1] | done_r[1])) : ok_end[0]);
  assign ss_ilim = ss & |(ilim_flt & in_on);

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      assign in_inr[c]  = st_r[c][1];
      assign in_on[c]   = st_r[c][2];
      assign cooling[c] = st_r[c][3];
      assign ch_on[c]   = in_inr[c] | in_on[c];
      assign pg[c]      = in_on[c];
      assign ok_end[c]  = in_inr[c] & inrush_end[c] & ~start_flt[c];
      assign bad_end[c] = in_inr[c] & inrush_end[c] & start_flt[c];

      // Next state of one channel
      always @* begin
        st_nxt[c] = st_r[c];
        case (st_r[c])
          `ST_IDLE: begin
            if (ss && ss_fail) begin
              st_nxt[c] = `ST_COOL;
            end else if (ss && ss_ok) begin
              st_nxt[c] = `ST_ON;
            end else if (ss && pwr_req[0] && grant_ok[0] && !temp_over
                         && (c == 0 || class_hi)) begin
              st_nxt[c] = `ST_INRUSH;
            end else if (!ss && pwr_req[c] && grant_ok[c] && !temp_over) begin
              st_nxt[c] = `ST_INRUSH;
            end
          end
          `ST_INRUSH: begin
            if (ss) begin
              if (ss_fail) begin
                st_nxt[c] = `ST_COOL;
              end else if (ss_ok) begin
                st_nxt[c] = `ST_ON;
              end
            end else if (bad_end[c]) begin
              st_nxt[c] = `ST_COOL;
            end else if (ok_end[c]) begin
              st_nxt[c] = `ST_ON;
            end
          end
          `ST_ON: begin
            // Overload drops the whole port or only this channel
            if ((ss && ss_ilim) || (!ss && ilim_flt[c])) begin
              st_nxt[c] = `ST_COOL;
            end
          end
          `ST_COOL: begin
            if (cnt_r[c] == COOL_CYCLES - 1) begin
              st_nxt[c] = `ST_IDLE;
            end
          end
          default: begin
            st_nxt[c] = `ST_IDLE;
          end
        endcase
        // Thermal shutdown overrides everything
        if (temp_over) begin
          st_nxt[c] = `ST_IDLE;
        end
      end

      // State, counter and event registers
      always @(posedge clk) begin
        if (rst) begin
          st_r[c]       <= `ST_IDLE;
          cnt_r[c]      <= {CNT_W{1'b0}};
          done_r[c]     <= 1'b0;
          sflt_evt_r[c] <= 1'b0;
          ilim_evt_r[c] <= 1'b0;
        end else begin
          st_r[c]       <= st_nxt[c];
          cnt_r[c]      <= (st_r[c] == `ST_COOL) ? cnt_r[c] + 1'b1 : {CNT_W{1'b0}};
          done_r[c]     <= in_inr[c] & (done_r[c] | ok_end[c]) & (st_nxt[c] == `ST_INRUSH);
          sflt_evt_r[c] <= ss ? ss_fail : bad_end[c];
          ilim_evt_r[c] <= ilim_flt[c] & in_on[c];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- design/pse_fault_event_reporting.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pse_event_defines.vh"

module pse_fault_event_reporting #(
  parameter integer NPORT       = 2,          // 4-pair ports in this group
  parameter integer COOL_CYCLES = `COOL_CYC,  // Cool-down length in cycles
  parameter integer CNT_W       = 26          // Cool-down counter width
) (
  // Clock and resets
  input  wire                 clk,
  input  wire                 srst,           // Reset pin, synchronous
  input  wire                 por,            // Power-on reset, synchronous
  // Management command port
  input  wire                 cmd_rd,         // Read command pulse
  input  wire [7:0]           cmd_code,       // Command code
  output reg  [7:0]           rd_data_r,      // Read data
  output reg                  rd_valid_r,     // Read data valid pulse
  // Mode and port configuration
  input  wire                 auto_mode,      // Automatic operating mode
  input  wire [NPORT-1:0]     dual_sig,       // Port load has two signatures
  input  wire [NPORT-1:0]     class_hi,       // Port assigned class 7 or 8
  // Per channel inputs
  input  wire [2*NPORT-1:0]   pwr_req,        // Power-on command pulse
  input  wire [2*NPORT-1:0]   grant_ok,       // Discovery valid, allocation fits
  input  wire [2*NPORT-1:0]   inrush_end,     // End of inrush pulse
  input  wire [2*NPORT-1:0]   start_flt,      // Start fault at inrush end
  input  wire [2*NPORT-1:0]   ilim_flt,       // Current-limit timeout pulse
  input  wire [2*NPORT-1:0]   disc_invalid,   // Invalid discovery pulse
  input  wire [2*NPORT-1:0]   power_enable_change_flag, // Power enable change flag
  input  wire [4*NPORT-1:0]   fault_cause,    // Two-bit cause per channel
  // Supply and fault events
  input  wire                 temp_over,      // Die above high threshold
  input  wire                 lockout_evt,    // Logic supply lockout
  input  wire                 warning_evt,    // Logic supply warning
  input  wire                 main_uv_evt,    // Main rail undervoltage
  input  wire                 summed_overload_fault_ch3_ch4, // Summed overload, second pair
  input  wire                 summed_overload_fault_ch1_ch2, // Summed overload, first pair
  input  wire                 fast_shut_evt,  // Fast shutdown or priority code
  input  wire                 mem_flt_evt,    // Program memory fault
  // Channel outputs
  output wire [2*NPORT-1:0]   ch_on,          // Channel switch enabled
  output wire [2*NPORT-1:0]   pg,             // Power good flags
  output wire [2*NPORT-1:0]   cooling,        // Cool-down in progress
  output reg  [2*NPORT-1:0]   inrush_flt_r,   // Start fault was an inrush fault
  output reg                  off_mode_r,     // Channels forced to off mode
  // Interrupt
  output wire                 sup_summary,    // Summary bit of supply events
  output wire                 int_n           // Interrupt, active low
);

  localparam integer NCH = 2 * NPORT;  // Channel count

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg  [7:0]       sup_r;     // Supply and fault events
  reg  [7:0]       sup_nxt;   // Next supply and fault events
  reg  [7:0]       si_r;      // Start and current-limit events
  reg  [7:0]       si_nxt;    // Next start and current-limit events
  reg  [7:0]       pf_r;      // Power-on fault causes
  reg  [7:0]       pf_nxt;    // Next power-on fault causes
  reg  [2*NCH-1:0] infl_nxt;  // Next inrush fault flags
  wire [7:0]       sup_set;   // Supply event set terms
  wire [NCH-1:0]   sflt_evt;  // Start fault events from sequencers
  wire [NCH-1:0]   ilim_evt;  // Current-limit events from sequencers
  wire [NCH-1:0]   sflt_set;  // Start flag set terms
  wire             rd_sup;    // Any read of supply events
  wire             clr_sup;   // Clear-on-read of supply events
  wire             clr_si;    // Clear-on-read of start events
  wire             any_rst;   // Either reset

  assign any_rst = srst | por;
  assign rd_sup  = cmd_rd & ((cmd_code == `CMD_SF_VIEW) | (cmd_code == `CMD_SF_CLR));
  assign clr_sup = cmd_rd & (cmd_code == `CMD_SF_CLR);
  assign clr_si  = cmd_rd & (cmd_code == `CMD_SI_CLR);

  // ----------------------------------------
  // Inrush sequencers, one per 4-pair port
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      port_inrush_seq #(
        .COOL_CYCLES (COOL_CYCLES),
        .CNT_W       (CNT_W)
      ) u_seq (
        .clk        (clk),
        .rst        (any_rst),
        .dual_sig   (dual_sig[p]),
        .class_hi   (class_hi[p]),
        .temp_over  (temp_over),
        .pwr_req    (pwr_req[2*p+1:2*p]),
        .grant_ok   (grant_ok[2*p+1:2*p]),
        .inrush_end (inrush_end[2*p+1:2*p]),
        .start_flt  (start_flt[2*p+1:2*p]),
        .ilim_flt   (ilim_flt[2*p+1:2*p]),
        .ch_on      (ch_on[2*p+1:2*p]),
        .pg         (pg[2*p+1:2*p]),
        .cooling    (cooling[2*p+1:2*p]),
        .sflt_evt_r (sflt_evt[2*p+1:2*p]),
        .ilim_evt_r (ilim_evt[2*p+1:2*p])
      );
    end
  endgenerate

  // ----------------------------------------
  // Start fault set terms per channel
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_set
      // Invalid discovery counts only outside automatic mode
      assign sflt_set[c] = sflt_evt[c] | (disc_invalid[c] & ~auto_mode);
    end
  endgenerate

  // ----------------------------------------
  // Start/current-limit event register
  // ----------------------------------------
  // Upper nibble current-limit, lower nibble start faults
  always @* begin
    si_nxt = si_r;
    if (clr_si) begin
      si_nxt = 8'h00;
    end
    // Set after clear so a coincident event survives
    si_nxt[7:4] = si_nxt[7:4] | ilim_evt;
    si_nxt[3:0] = si_nxt[3:0] | sflt_set;
  end

  // ----------------------------------------
  // Power-on fault causes and inrush flags
  // ----------------------------------------
  integer k;
  always @* begin
    pf_nxt   = pf_r;
    infl_nxt = {{NCH{1'b0}}, inrush_flt_r};
    for (k = 0; k < NCH; k = k + 1) begin
      if (sflt_evt[k] && power_enable_change_flag[k]) begin
        // Enable-change flag set: fault belongs to inrush
        infl_nxt[k] = 1'b1;
      end else if (sflt_evt[k]) begin
        // Otherwise the cause is logged
        pf_nxt[2*k +: 2] = fault_cause[2*k +: 2];
      end else if (disc_invalid[k] && !auto_mode) begin
        // Discovery failure logged only outside automatic mode
        pf_nxt[2*k +: 2] = `CAUSE_DISC;
      end
      // A new power-up attempt retires the old inrush verdict
      if (pwr_req[k] && !sflt_evt[k]) begin
        infl_nxt[k] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Supply_fault_events_clear set terms
  // ----------------------------------------
  assign sup_set[`SF_THERMAL]   = temp_over;
  assign sup_set[`SF_LOCKOUT]   = lockout_evt;
  assign sup_set[`SF_WARNING]   = warning_evt;
  assign sup_set[`SF_MAIN_UV]   = main_uv_evt;
  assign sup_set[`SF_OVL34]     = summed_overload_fault_ch3_ch4;
  assign sup_set[`SF_OVL12]     = summed_overload_fault_ch1_ch2;
  assign sup_set[`SF_FAST_SHUT] = fast_shut_evt;
  assign sup_set[`SF_MEM_FLT]   = mem_flt_evt;

  // Next value of supply events, set wins over clear
  always @* begin
    sup_nxt = sup_r;
    if (clr_sup) begin
      sup_nxt = 8'h00;
    end
    sup_nxt = sup_nxt | sup_set;
  end

  // ----------------------------------------
  // Supply_fault_events_clear register
  // ----------------------------------------
  // Power-on sets bits 6 to 4; pin reset keeps the supply bits
  always @(posedge clk) begin
    if (por) begin
      sup_r <= `SF_POR_VAL;
    end else if (srst) begin
      sup_r <= sup_r & `SF_KEEP_MASK;
    end else begin
      sup_r <= sup_nxt;
    end
  end

  // ----------------------------------------
  // Channel event registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (any_rst) begin
      si_r         <= `SI_RST_VAL;
      pf_r         <= `PF_RST_VAL;
      inrush_flt_r <= {NCH{1'b0}};
    end else begin
      si_r         <= si_nxt;
      pf_r         <= pf_nxt;
      inrush_flt_r <= infl_nxt[NCH-1:0];
    end
  end

  // ----------------------------------------
  // Thermal off mode
  // ----------------------------------------
  // Follows temperature, not the sticky flag
  always @(posedge clk) begin
    if (any_rst) begin
      off_mode_r <= 1'b0;
    end else begin
      off_mode_r <= temp_over;
    end
  end

  // ----------------------------------------
  // Command read path
  // ----------------------------------------
  // Both supply codes return the pre-clear value
  always @(posedge clk) begin
    if (any_rst) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= cmd_rd;
      if (cmd_rd) begin
        if (rd_sup) begin
          rd_data_r <= sup_r;
        end else if ((cmd_code == `CMD_SI_VIEW) || (cmd_code == `CMD_SI_CLR)) begin
          rd_data_r <= si_r;
        end else if (cmd_code == `CMD_PON_FLT) begin
          rd_data_r <= pf_r;
        end else begin
          // Unmapped code reads zero
          rd_data_r <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt summary
  // ----------------------------------------
  // Any set event bit raises summary; clearing releases it
  assign sup_summary = |sup_r;
  assign int_n       = ~(sup_summary | (|si_r));

endmodule

`default_nettype wire

// ---- tb/pse_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Host side of the command port
// ----
module pse_host_model (
  // Clock
  input  wire logic       clk,
  // Command port
  output var  logic       cmd_rd,
  output var  logic [7:0] cmd_code,
  input  wire logic [7:0] rd_data_r,
  input  wire logic       rd_valid_r
);
  // Idle port
  initial begin
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
  end
  // One read: request for one cycle, answer taken the cycle after
  task automatic rd(input logic [7:0] code, output logic [7:0] d);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= code;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~code;  // Code not held past its request
    @(negedge clk);
    d = rd_valid_r ? rd_data_r : 8'hxx;  // Missing answer reads as unknown
  endtask
endmodule
`default_nettype wire

// ---- tb/pse_fault_event_reporting_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pse_event_defines.vh"
// ----
// Event register and inrush checks
// ----
module pse_fault_event_reporting_sva #(
  parameter integer NPORT = 2  // Ports in the group
) (
  // Clock, resets, command port
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 por,
  input wire logic                 cmd_rd,
  input wire logic [7:0]           cmd_code,
  input wire logic                 rd_valid_r,
  // Configuration and channel stimulus
  input wire logic [NPORT-1:0]     dual_sig,
  input wire logic [NPORT-1:0]     class_hi,
  input wire logic [2*NPORT-1:0]   inrush_end,
  input wire logic [2*NPORT-1:0]   start_flt,
  input wire logic [2*NPORT-1:0]   ilim_flt,
  // Supply events
  input wire logic                 temp_over,
  input wire logic                 lockout_evt,
  input wire logic                 warning_evt,
  input wire logic                 main_uv_evt,
  input wire logic                 summed_overload_fault_ch3_ch4,
  input wire logic                 summed_overload_fault_ch1_ch2,
  input wire logic                 fast_shut_evt,
  input wire logic                 mem_flt_evt,
  // Results
  input wire logic [2*NPORT-1:0]   ch_on,
  input wire logic [2*NPORT-1:0]   pg,
  input wire logic [2*NPORT-1:0]   cooling,
  input wire logic                 off_mode_r,
  input wire logic                 sup_summary,
  input wire logic                 int_n
);
  // All supply event inputs together
  wire [7:0] evt_in = {temp_over, lockout_evt, warning_evt, main_uv_evt,
                       summed_overload_fault_ch3_ch4, summed_overload_fault_ch1_ch2,
                       fast_shut_evt, mem_flt_evt};
  a_read_pulse: assert property (@(posedge clk) disable iff (srst || por)
    rd_valid_r == $past(cmd_rd && !srst && !por)) else $error("read answer misplaced");
  a_clear_release: assert property (@(posedge clk) disable iff (srst || por)
    cmd_rd && cmd_code == `CMD_SF_CLR && evt_in == 8'h00 |=> !sup_summary)
    else $error("clear read left supply summary set");
  a_summary_int: assert property (@(posedge clk) disable iff (srst || por)
    sup_summary |-> !int_n) else $error("supply event without interrupt");
  a_thermal_off: assert property (@(posedge clk) disable iff (srst || por)
    temp_over |=> ch_on == '0 && off_mode_r) else $error("channels on in thermal shutdown");
  a_por_flags: assert property (@(posedge clk) disable iff (srst)
    $fell(por) |-> sup_summary && !int_n) else $error("supply flags not set by power-on");
  a_one_inrush: assert property (@(posedge clk) disable iff (srst || por)
    !dual_sig[0] && !class_hi[0] && ch_on[0] && !pg[0] |-> !ch_on[1])
    else $error("second channel on during low-class inrush");
  a_pair_inrush: assert property (@(posedge clk) disable iff (srst || por)
    !dual_sig[0] && class_hi[0] |-> ch_on[0] == ch_on[1]) else $error("high-class pair split");
  a_clean_start: assert property (@(posedge clk) disable iff (srst || por)
    !dual_sig[0] && !class_hi[0] && ch_on[0] && !pg[0] && inrush_end[0] && !start_flt[0]
    && !temp_over |=> ch_on[1:0] == 2'b11 && pg[1:0] == 2'b11) else $error("clean start missed");
  a_fault_cool: assert property (@(posedge clk) disable iff (srst || por)
    !dual_sig[0] && ch_on[0] && !pg[0] && inrush_end[0] && start_flt[0] && !temp_over
    |=> cooling[1:0] == 2'b11 && ch_on[1:0] == 2'b00) else $error("start fault not cooled");
  a_dual_indep: assert property (@(posedge clk) disable iff (srst || por)
    dual_sig[0] && ch_on[1] && inrush_end[0] && start_flt[0] && !inrush_end[1]
    && !ilim_flt[1] && !temp_over |=> ch_on[1]) else $error("dual channel disturbed");
endmodule
bind pse_fault_event_reporting pse_fault_event_reporting_sva #(.NPORT(NPORT))
  pse_fault_event_reporting_sva_i (.clk, .srst, .por, .cmd_rd, .cmd_code, .rd_valid_r,
  .dual_sig, .class_hi, .inrush_end, .start_flt, .ilim_flt, .temp_over, .lockout_evt,
  .warning_evt, .main_uv_evt, .summed_overload_fault_ch3_ch4,
  .summed_overload_fault_ch1_ch2, .fast_shut_evt, .mem_flt_evt,
  .ch_on, .pg, .cooling, .off_mode_r, .sup_summary, .int_n);
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pse_event_defines.vh"
// ----
// Bench top
// ----
module tb;
  localparam integer COOL = 16;  // Short cool-down
  // Stimulus
  logic       clk, srst, por, auto_mode;
  logic [1:0] dual_sig, class_hi;
  logic [3:0] pwr_req, grant_ok, inrush_end, start_flt, ilim_flt, disc_invalid;
  logic [3:0] power_enable_change_flag;
  logic [7:0] fault_cause, evt, d;
  // Observed
  logic       cmd_rd, rd_valid_r, off_mode_r, sup_summary, int_n;
  logic [7:0] cmd_code, rd_data_r;
  logic [3:0] ch_on, pg, cooling, inrush_flt_r;
  int         err_count, cmp_count;
  pse_fault_event_reporting #(.COOL_CYCLES(COOL), .CNT_W(8)) pse_fault_event_reporting_i (
    .clk, .srst, .por, .cmd_rd, .cmd_code, .rd_data_r, .rd_valid_r, .auto_mode, .dual_sig,
    .class_hi, .pwr_req, .grant_ok, .inrush_end, .start_flt, .ilim_flt, .disc_invalid,
    .power_enable_change_flag, .fault_cause, .temp_over(evt[7]), .lockout_evt(evt[6]),
    .warning_evt(evt[5]), .main_uv_evt(evt[4]), .summed_overload_fault_ch3_ch4(evt[3]),
    .summed_overload_fault_ch1_ch2(evt[2]), .fast_shut_evt(evt[1]),
    .mem_flt_evt(evt[0]), .ch_on, .pg, .cooling, .inrush_flt_r, .off_mode_r, .sup_summary,
    .int_n);
  pse_host_model pse_host_model_i (.clk, .cmd_rd, .cmd_code, .rd_data_r, .rd_valid_r);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read through the host and compare
  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    pse_host_model_i.rd(code, d);
    chk(d, exp);
  endtask
  // Channel pulse: 0 power-on, 1 inrush end, 2 current limit, 3 invalid discovery
  task automatic pl(input int k, input logic [3:0] m, input logic [3:0] f);
    @(posedge clk);
    start_flt <= f;
    case (k)
      0: pwr_req <= m;
      1: inrush_end <= m;
      2: ilim_flt <= m;
      default: disc_invalid <= m;
    endcase
    @(posedge clk);
    {pwr_req, inrush_end, ilim_flt, disc_invalid} <= '0;
    @(negedge clk);
  endtask
  // One-cycle supply events
  task automatic ev(input logic [7:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 8'h00;
    @(negedge clk);
  endtask
  // Two-cycle reset: pin or power-on
  task automatic rst(input logic p);
    @(posedge clk);
    if (p) por <= 1'b1;
    else srst <= 1'b1;
    repeat (2) @(posedge clk);
    {srst, por} <= 2'b00;
  endtask
  // Wait cycles, end settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Verdict
  task automatic end_sim;
    $display("Compares %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    {srst, por, auto_mode, dual_sig, class_hi, evt, fault_cause} = '0;
    {srst, por} = 2'b11;
    {pwr_req, inrush_end, start_flt, ilim_flt, disc_invalid} = '0;
    {grant_ok, power_enable_change_flag} = 8'hf1;
    {err_count, cmp_count} = '0;
    repeat (2) @(posedge clk);
    {srst, por} <= 2'b00;
    rd(`CMD_SF_VIEW, 8'h70);
    rd(`CMD_SF_CLR, 8'h70);
    rd(`CMD_SF_VIEW, 8'h00);
    chk(int_n, 1'b1);
    for (int i = 0; i < 8; i++) begin
      ev(8'h01 << i);
      rd(`CMD_SF_VIEW, 8'h01 << i);
      chk({sup_summary, int_n}, 2'b10);
      rd(`CMD_SF_CLR, 8'h01 << i);
      chk(int_n, 1'b1);
    end
    // Event in the very cycle of a clear read
    fork
      pse_host_model_i.rd(`CMD_SF_CLR, d);
      ev(8'h02);
    join
    chk(d, 8'h00);
    rd(`CMD_SF_CLR, 8'h02);
    ev(8'hff);
    rst(1'b0);
    rd(`CMD_SF_VIEW, 8'hf0);
    rst(1'b1);
    rd(`CMD_SF_CLR, 8'h70);
    // Low-class single signature
    pl(0, 4'h1, 4'h0);
    chk({ch_on, pg}, 8'h10);
    pl(1, 4'h1, 4'h0);
    chk({ch_on, pg}, 8'h33);
    ev(8'h80);
    chk({ch_on, off_mode_r}, 5'h01);
    pl(0, 4'h1, 4'h0);
    chk(ch_on, 4'h1);
    pl(1, 4'h1, 4'h1);
    chk({ch_on, cooling}, 8'h03);
    rd(`CMD_SI_CLR, 8'h03);
    chk(inrush_flt_r, 4'h1);
    cyc(COOL - 6);
    chk(cooling, 4'h3);
    cyc(8);
    chk(cooling, 4'h0);
    // High-class single signature
    @(posedge clk);
    class_hi <= 2'b01;
    fault_cause <= 8'h0c;
    pl(0, 4'h1, 4'h0);
    chk(ch_on, 4'h3);
    pl(1, 4'h2, 4'h2);
    chk({ch_on, cooling}, 8'h03);
    rd(`CMD_SI_CLR, 8'h03);
    rd(`CMD_PON_FLT, 8'h0c);
    cyc(COOL + 4);
    pl(0, 4'h1, 4'h0);
    pl(1, 4'h1, 4'h0);
    chk(pg, 4'h0);
    pl(1, 4'h2, 4'h0);
    chk({ch_on, pg}, 8'h33);
    pl(2, 4'h1, 4'h0);
    rd(`CMD_SI_CLR, 8'h10);
    cyc(COOL + 4);
    // Dual signature
    @(posedge clk);
    {dual_sig, class_hi} <= 4'h4;
    pl(0, 4'h3, 4'h0);
    chk(ch_on, 4'h3);
    pl(1, 4'h1, 4'h1);
    chk({ch_on, cooling}, 8'h21);
    pl(1, 4'h2, 4'h0);
    chk({ch_on, pg}, 8'h22);
    rd(`CMD_SI_CLR, 8'h01);
    cyc(COOL + 4);
    pl(0, 4'h1, 4'h0);
    chk(ch_on, 4'h3);
    pl(2, 4'h2, 4'h0);
    chk(ch_on, 4'h1);
    rd(`CMD_SI_CLR, 8'h20);
    // Manual mode logs invalid discovery
    pl(3, 4'h4, 4'h0);
    rd(`CMD_SI_CLR, 8'h04);
    // Automatic mode ignores invalid discovery
    @(posedge clk);
    auto_mode <= 1'b1;
    pl(3, 4'h8, 4'h0);
    rd(`CMD_SI_VIEW, 8'h00);
    rd(`CMD_PON_FLT, 8'h1c);
    rd(8'h55, 8'h00);
    end_sim;
  end
endmodule
`default_nettype wire
